// >>> rtl/bpe_pkg.sv
// Package of constants for the booster phase enable and multiphase control block.
package bpe_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] BPE_CTRL_OFS = 8'h00;
    localparam logic [7:0] BPE_STAT_OFS = 8'h04;
    localparam logic [7:0] BPE_FSCLR_OFS = 8'h08;

    // ************************************************************
    // Control register fields and reset value
    // ************************************************************
    localparam int BPE_SW_EN_LSB = 0;
    localparam int BPE_PIN_SEL_BIT = 2;
    localparam int BPE_SYNC_INV_BIT = 3;
    localparam int BPE_ROLE_LSB = 4;
    localparam int BPE_GAIN_LSB = 6;
    localparam int BPE_SKIP_LSB = 8;
    localparam int BPE_FSFREQ_LSB = 10;
    localparam logic [12:0] BPE_CTRL_RST = 13'h00C0;

    // ************************************************************
    // Field encodings
    // ************************************************************
    localparam logic [1:0] BPE_SKIP_OFF = 2'h0;
    localparam logic [1:0] BPE_GAIN_OFF = 2'h0;
    localparam logic [1:0] BPE_ROLE_MASTER = 2'h1;
    localparam logic [1:0] BPE_ROLE_SLAVE = 2'h2;

    // ************************************************************
    // Timing, pin count and PWM sources
    // ************************************************************
    localparam int BPE_CLK_MHZ = 100;
    localparam int BPE_FS_BASE_KHZ = 200;
    localparam int BPE_FS_PERIOD_BASE = BPE_CLK_MHZ * 1000 / BPE_FS_BASE_KHZ;
    localparam int BPE_FS_PERIOD_STEP = 50;
    localparam int BPE_EXT_DEB_CYC = 8;
    localparam int BPE_PIN_NUM = 9;

    typedef enum logic [1:0] {
        BPE_SRC_SYNC,
        BPE_SRC_FS
    } bpe_src_t;

endpackage

// >>> rtl/bpe_ctrl.sv
// Phase enable, multiphase role, sync and skip-cycle control with an APB register file.
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps

// How it works
// - Skip selection 00 never suppresses PWM pulses.
// - Nonzero skip selection stops gate pulses while compensation voltage is below its threshold.
// - Gain field 00 disables the error amplifier; host writes 00 on slaves.
// - Role 01 is master; its amplifier drives the shared compensation node.
// - Role 10 is slave; the compensation node is only sensed, not driven.
// - Overvoltage blocks gate pulses locally; host programs equal thresholds.
// - Pin select 0: falling edge on the shared pin enters fail-safe mode.
// - Pin select 0: phase enables on enable bit rising, disables on falling.
// - Pin select 1: phase runs only with enable bit and debounced pin high.
// - Enable bit 0 turns the phase off and holds its gate low.
// - Amplifier is never switched off automatically when all phases are off.
// - Sync input sampled and edge-debounced over two cycles; inversion picks edge.
// - Fail-safe mode switches PWM source to an internal divider at selected frequency.
module bpe_ctrl
    import bpe_pkg::*;
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic booster_sync_input_i,
    input wire logic failsafe_or_enable_pin_i,
    input wire logic phase_ext_enable_pin_i,
    input wire logic boost_overvolt_i,
    input wire logic [2:0] comp_below_thr_i,
    input wire logic [1:0] peak_reached_i,
    output logic [1:0] gate_o,
    output logic [1:0] err_amp_gain_o,
    output logic err_amp_en_o,
    output logic comp_drive_en_o,
    output logic fail_safe_mode_o
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    // Bit order: 0 sync, 1 shared pin, 2 ext enable, 3 overvoltage, 6:4 thresholds, 8:7 peak.
    logic [BPE_PIN_NUM-1:0] pin_raw;
    logic [BPE_PIN_NUM-1:0] sy1_r;
    logic [BPE_PIN_NUM-1:0] sy2_r;
    logic [BPE_PIN_NUM-1:0] sy3_r;
    logic [BPE_PIN_NUM-1:0] flt_r;
    logic [BPE_PIN_NUM-1:0] flt_d_r;

    assign pin_raw = {peak_reached_i, comp_below_thr_i, boost_overvolt_i,
                      phase_ext_enable_pin_i, failsafe_or_enable_pin_i, booster_sync_input_i};

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sy1_r <= '0;
            sy2_r <= '0;
            sy3_r <= '0;
        end else begin
            sy1_r <= pin_raw;
            sy2_r <= sy1_r;
            sy3_r <= sy2_r;
        end
    end

    // A change only counts once two samples agree, which is the two-cycle edge debounce.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            flt_r <= '0;
            flt_d_r <= '0;
        end else begin
            for (int i = 0; i < BPE_PIN_NUM; i++) begin
                if (sy2_r[i] == sy3_r[i]) begin
                    flt_r[i] <= sy3_r[i];
                end
            end
            flt_d_r <= flt_r;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    logic [12:0] ctrl_r;
    logic fs_r;
    logic [1:0] run;
    logic [1:0] sw_en;
    logic pin_sel;
    logic sync_inv;
    logic [1:0] role;
    logic [1:0] skip_sel;
    logic [2:0] fs_freq;
    logic wr_ok;
    logic map_hit;
    logic [31:0] rd_nxt;

    assign sw_en = ctrl_r[BPE_SW_EN_LSB +: 2];
    assign pin_sel = ctrl_r[BPE_PIN_SEL_BIT];
    assign sync_inv = ctrl_r[BPE_SYNC_INV_BIT];
    assign role = ctrl_r[BPE_ROLE_LSB +: 2];
    assign err_amp_gain_o = ctrl_r[BPE_GAIN_LSB +: 2];
    assign skip_sel = ctrl_r[BPE_SKIP_LSB +: 2];
    assign fs_freq = ctrl_r[BPE_FSFREQ_LSB +: 3];

    assign map_hit = (paddr_i == BPE_CTRL_OFS) || (paddr_i == BPE_STAT_OFS)
                     || (paddr_i == BPE_FSCLR_OFS);
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !map_hit;
    assign wr_ok = psel_i && penable_i && pwrite_i;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ctrl_r <= BPE_CTRL_RST;
        end else if (wr_ok && paddr_i == BPE_CTRL_OFS) begin
            ctrl_r <= pwdata_i[12:0];
        end
    end

    always_comb begin
        rd_nxt = 32'h0;
        if (paddr_i == BPE_CTRL_OFS) begin
            rd_nxt = {19'h0, ctrl_r};
        end else if (paddr_i == BPE_STAT_OFS) begin
            rd_nxt = {25'h0, flt_r[3], gate_o, comp_drive_en_o, err_amp_en_o, fs_r, run[1]};
            rd_nxt[7] = run[0];
        end
    end

    // Read data is loaded in the setup cycle so that it comes from a flip-flop.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            prdata_o <= 32'h0;
        end else if (psel_i && !penable_i) begin
            prdata_o <= rd_nxt;
        end
    end

    // ************************************************************
    // Fail-safe entry and exit
    // ************************************************************
    logic fs_fall;
    assign fs_fall = !pin_sel && flt_d_r[1] && !flt_r[1];

    // Entry wins over a software clear in the same cycle.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            fs_r <= 1'b0;
        end else if (fs_fall) begin
            fs_r <= 1'b1;
        end else if (wr_ok && paddr_i == BPE_FSCLR_OFS && pwdata_i[0]) begin
            fs_r <= 1'b0;
        end
    end
    assign fail_safe_mode_o = fs_r;

    // ************************************************************
    // Phase enables
    // ************************************************************
    logic [1:0] sw_d_r;
    logic [1:0] edge_run_r;
    logic [1:0] ext_deb_r;
    logic [1:0] ext_lvl;
    logic [3:0] deb_cnt_r [2];

    assign ext_lvl = {flt_r[1], flt_r[2]};

    // The shared pin is debounced too, even when it serves as fail-safe trigger.
    for (genvar g = 0; g < 2; g++) begin : g_deb
        always_ff @(posedge clk_i) begin
            if (srst_i) begin
                deb_cnt_r[g] <= 4'h0;
                ext_deb_r[g] <= 1'b0;
            end else if (ext_lvl[g] == ext_deb_r[g]) begin
                deb_cnt_r[g] <= 4'h0;
            end else if (deb_cnt_r[g] == 4'(BPE_EXT_DEB_CYC - 1)) begin
                deb_cnt_r[g] <= 4'h0;
                ext_deb_r[g] <= ext_lvl[g];
            end else begin
                deb_cnt_r[g] <= deb_cnt_r[g] + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sw_d_r <= 2'h0;
            edge_run_r <= 2'h0;
        end else begin
            sw_d_r <= sw_en;
            for (int i = 0; i < 2; i++) begin
                if (sw_en[i] && !sw_d_r[i]) begin
                    edge_run_r[i] <= 1'b1;
                end else if (!sw_en[i] && sw_d_r[i]) begin
                    edge_run_r[i] <= 1'b0;
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (!sw_en[i]) begin
                run[i] = 1'b0;
            end else if (pin_sel) begin
                run[i] = ext_deb_r[i];
            end else begin
                run[i] = edge_run_r[i];
            end
        end
    end

    // ************************************************************
    // Amplifier and compensation node
    // ************************************************************
    // The amplifier follows the gain field only; phases being off do not stop it.
    assign err_amp_en_o = (err_amp_gain_o != BPE_GAIN_OFF);
    assign comp_drive_en_o = err_amp_en_o && (role != BPE_ROLE_SLAVE);

    // ************************************************************
    // PWM source and gates
    // ************************************************************
    logic [9:0] fs_cnt_r;
    logic [9:0] fs_period;
    logic sync_rise;
    logic sync_fall;
    logic [1:0] start;
    logic skip;
    bpe_src_t src;

    assign fs_period = 10'(BPE_FS_PERIOD_BASE) - 10'(fs_freq) * 10'(BPE_FS_PERIOD_STEP);
    assign src = fs_r ? BPE_SRC_FS : BPE_SRC_SYNC;

    always_ff @(posedge clk_i) begin
        if (srst_i || !fs_r || fs_cnt_r >= fs_period - 10'h1) begin
            fs_cnt_r <= 10'h0;
        end else begin
            fs_cnt_r <= fs_cnt_r + 10'h1;
        end
    end

    assign sync_rise = flt_r[0] && !flt_d_r[0];
    assign sync_fall = !flt_r[0] && flt_d_r[0];

    always_comb begin
        case (src)
            BPE_SRC_SYNC: begin
                start[0] = sync_inv ? sync_fall : sync_rise;
                start[1] = sync_inv ? sync_rise : sync_fall;
            end
            BPE_SRC_FS: begin
                start[0] = fs_cnt_r == 10'h0;
                start[1] = fs_cnt_r == (fs_period >> 1);
            end
            default: start = 2'h0;
        endcase
    end

    // Thresholds are external comparators; only the selected one counts.
    assign skip = (skip_sel != BPE_SKIP_OFF) && flt_r[4 + int'(skip_sel) - 1];

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            gate_o <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (!run[i] || skip || flt_r[3]) begin
                    gate_o[i] <= 1'b0;
                end else if (start[i]) begin
                    gate_o[i] <= 1'b1;
                end else if (flt_r[7 + i]) begin
                    gate_o[i] <= 1'b0;
                end
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    skip_off_pass_a: assert property ((skip_sel == BPE_SKIP_OFF && run[0] && !flt_r[3]
        && start[0]) |=> gate_o[0])
        else $error("skip disabled but pulse suppressed");
    skip_gate_low_a: assert property (skip |=> !gate_o[0] && !gate_o[1])
        else $error("gate active while skipping");
    gain_amp_off_a: assert property ((err_amp_gain_o == BPE_GAIN_OFF) |-> !err_amp_en_o
        && !comp_drive_en_o)
        else $error("amplifier on with zero gain");
    master_drive_a: assert property ((role == BPE_ROLE_MASTER && err_amp_en_o)
        |-> comp_drive_en_o)
        else $error("master not driving node");
    slave_sense_a: assert property ((role == BPE_ROLE_SLAVE) |-> !comp_drive_en_o)
        else $error("slave drives node");
    ov_gate_low_a: assert property (flt_r[3] |=> gate_o == 2'h0)
        else $error("gate active in overvoltage");
    fs_entry_a: assert property ((!pin_sel && $fell(flt_r[1])) |=> fail_safe_mode_o)
        else $error("fail-safe not entered");
    edge_enable_a: assert property ((!pin_sel && $rose(sw_en[0])) |=> edge_run_r[0]
        ##0 run[0] || !sw_en[0])
        else $error("phase not enabled by rising bit");
    edge_disable_a: assert property ((!pin_sel && $fell(sw_en[0])) |=> !edge_run_r[0])
        else $error("phase not disabled by falling bit");
    pin_and_a: assert property (pin_sel |-> run == (sw_en & ext_deb_r))
        else $error("pin mode enable mismatch");
    pin_gate_low_a: assert property ((pin_sel && !ext_deb_r[0]) |=> !gate_o[0])
        else $error("gate active with enable pin low");
    sw_off_a: assert property (!sw_en[1] |=> !gate_o[1])
        else $error("gate active with enable bit low");
    amp_stays_a: assert property ((run == 2'h0 && err_amp_gain_o != BPE_GAIN_OFF)
        |-> err_amp_en_o)
        else $error("amplifier switched off automatically");
    sync_edge_a: assert property ((!fs_r && !sync_inv && $rose(flt_r[0])) |-> start[0])
        else $error("sync rising edge missed");
    sync_fall_a: assert property ((!fs_r && !sync_inv && $fell(flt_r[0])) |-> start[1])
        else $error("sync falling edge missed");
    sync_inv_a: assert property ((!fs_r && sync_inv && $fell(flt_r[0])) |-> start[0])
        else $error("inverted sync edge missed");
    fs_source_a: assert property (fs_r |-> !(start[0] && fs_cnt_r != 10'h0))
        else $error("external sync used in fail-safe");
    // A stray sync edge in fail-safe mode must not start a phase 0 pulse off the divider grid.
    fs_no_sync_a: assert property ((fs_r && fs_cnt_r != 10'h0) |=> !$rose(gate_o[0]))
        else $error("phase 0 started off the internal divider");
    // The counter must have run its full length before the debounced level moves.
    deb_hold_a: assert property ($changed(ext_deb_r[0])
        |-> $past(deb_cnt_r[0]) == 4'(BPE_EXT_DEB_CYC - 1))
        else $error("ext enable changed too early");

    cov_fs_c: cover property ($rose(fail_safe_mode_o));
    cov_pin_run_c: cover property (pin_sel && run == 2'h3);
    cov_skip_c: cover property (skip_sel != BPE_SKIP_OFF && skip);
    cov_gate_c: cover property ($rose(gate_o[1]));
    cov_fs_pulse_c: cover property (fail_safe_mode_o && $rose(gate_o[0]));

endmodule

// >>> tb/bpe_host_model.sv
// Host-side model that supplies the shared booster sync clock.
`timescale 1ns/1ps
module bpe_host_model #(
    parameter int HALF = 40
) (
    input wire logic clk_i,
    input wire logic run_i,
    output logic sync_o
);
    // ********************************
    // Sync clock
    // ********************************
    // The line rests low while the host is stopped, so a halted host gives no stray edges.
    int cnt = 0;
    logic sync_r = 1'b0;
    assign sync_o = sync_r;
    always @(posedge clk_i) begin
        if (!run_i) begin
            cnt <= 0;
            sync_r <= 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            sync_r <= ~sync_r;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

// >>> tb/bpe_ctrl_tb.sv
// Self-checking bench for the booster phase enable and multiphase control block.
`timescale 1ns/1ps
module bpe_ctrl_tb
    import bpe_pkg::*;
;
    // ********************************
    // Signals, instances and helpers
    // ********************************
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, pready_o, pslverr_o;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd, ex;
    logic ov_i = 1'b0, ext_i = 1'b0, fs_i = 1'b1, run = 1'b1, sync, err, hit;
    logic [2:0] below_i = 3'h0, below_on = 3'h0, below_off = 3'h0, ffs = 3'h7;
    logic [1:0] peak_i = 2'h0, gate_o, gain_o;
    logic amp_en_o, drive_o, fsm_o;
    int n_errors = 0;
    int n_tests = 0;
    int d;

    always #5 clk_i = ~clk_i;

    // Peak ends come often at random, so each pulse ends long before the next start.
    always @(posedge clk_i) begin
        peak_i <= {($urandom % 4 == 0), ($urandom % 4 == 0)};
        below_i <= (3'($urandom) | below_on) & ~below_off;
    end

    bpe_ctrl bpe_ctrl_i (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .booster_sync_input_i(sync), .failsafe_or_enable_pin_i(fs_i),
        .phase_ext_enable_pin_i(ext_i), .boost_overvolt_i(ov_i), .comp_below_thr_i(below_i),
        .peak_reached_i(peak_i), .gate_o(gate_o), .err_amp_gain_o(gain_o),
        .err_amp_en_o(amp_en_o), .comp_drive_en_o(drive_o), .fail_safe_mode_o(fsm_o));

    bpe_host_model bpe_host_model_i (.clk_i(clk_i), .run_i(run), .sync_o(sync));

    function automatic logic [31:0] ctrl(input logic [1:0] en, input logic sel, input logic inv,
            input logic [1:0] role, input logic [1:0] gain, input logic [1:0] skip);
        return (32'(en) << BPE_SW_EN_LSB) | (32'(sel) << BPE_PIN_SEL_BIT)
            | (32'(inv) << BPE_SYNC_INV_BIT) | (32'(role) << BPE_ROLE_LSB)
            | (32'(gain) << BPE_GAIN_LSB) | (32'(skip) << BPE_SKIP_LSB)
            | (32'(ffs) << BPE_FSFREQ_LSB);
    endfunction

    function automatic int fs_exp(input logic [2:0] f);
        return BPE_FS_PERIOD_BASE - BPE_FS_PERIOD_STEP * int'(f);
    endfunction

    function automatic logic [31:0] amp_exp(input logic [1:0] role, input logic [1:0] gain);
        logic en;
        en = (gain != BPE_GAIN_OFF);
        return {28'h0, gain, en, en && (role != BPE_ROLE_SLAVE)};
    endfunction

    task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
        n_tests++;
        if (seen_v !== exp_v) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen_v, exp_v);
        end
    endtask

    task automatic close_out();
        $display("mismatches %0d comparisons %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic give_up();
        n_errors++;
        close_out();
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= wd;
        @(posedge clk_i);
        penable_i <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (pready_o !== 1'b1 && k < 50);
        if (k == 50) give_up();
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        #1;
    endtask

    task automatic seen(input int n, input logic [1:0] m);
        hit = 1'b0;
        repeat (n) begin
            @(posedge clk_i);
            #1;
            hit = hit | (|(gate_o & m));
        end
    endtask

    task automatic pins(input logic ov, input logic ext, input logic fs, input logic r);
        @(posedge clk_i);
        ov_i <= ov;
        ext_i <= ext;
        fs_i <= fs;
        run <= r;
    endtask

    // Waits for sync to reach lvl, then counts cycles until gate bit b rises.
    task automatic gap(input logic lvl, input int b);
        logic p;
        p = sync;
        for (d = 0; d < 200 && !(sync === lvl && p !== lvl); d++) begin
            p = sync;
            seen(1, 2'h0);
        end
        if (d == 200) give_up();
        for (d = 0; d < 60 && gate_o[b] !== 1'b1; d++) begin
            seen(1, 2'h0);
        end
        if (d == 60) give_up();
    endtask

    // Counts cycles from the current sample to the next rise of the phase 0 gate.
    task automatic rise0(output int n);
        logic p;
        p = gate_o[0];
        for (n = 0; n < 600 && !(gate_o[0] === 1'b1 && p === 1'b0); n++) begin
            p = gate_o[0];
            seen(1, 2'h0);
        end
        if (n == 600) give_up();
    endtask

    // ********************************
    // Main sequence
    // ********************************
    initial begin
        d = $urandom(96);
        repeat (6) @(posedge clk_i);
        srst_i <= 1'b0;
        apb(1'b0, BPE_CTRL_OFS, 32'h0);
        check(rd, 32'(BPE_CTRL_RST));
        check({28'h0, gate_o, fsm_o, amp_en_o}, 32'h1);
        apb(1'b0, 8'h0C, 32'h0);
        check({rd[30:0], err}, 32'h1);
        apb(1'b1, BPE_STAT_OFS, 32'hFFFF_FFFF);
        apb(1'b0, BPE_CTRL_OFS, 32'h0);
        check(rd, 32'(BPE_CTRL_RST));
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, BPE_CTRL_OFS, ctrl(2'h0, 1'b0, 1'b0, 2'(i >> 2), 2'(i), BPE_SKIP_OFF));
            ex = amp_exp(2'(i >> 2), 2'(i));
            check({28'h0, gain_o, amp_en_o, drive_o}, ex);
        end
        // The slave takes inverted sync and a zero gain; the master keeps both defaults.
        for (int v = 0; v < 2; v++) begin
            apb(1'b1, BPE_CTRL_OFS, ctrl(2'h3, 1'b0, 1'(v), v ? BPE_ROLE_SLAVE : BPE_ROLE_MASTER,
                v ? BPE_GAIN_OFF : 2'h3, BPE_SKIP_OFF));
            gap(1'(v == 0), 0);
            check(32'(d >= 2 && d <= 10), 32'h1);
            gap(1'(v != 0), 1);
            check(32'(d >= 2 && d <= 10), 32'h1);
        end
        for (int k = 0; k < 4; k++) begin
            below_on = (k == 0) ? 3'h7 : 3'(1 << (k - 1));
            apb(1'b1, BPE_CTRL_OFS, ctrl(2'h3, 1'b0, 1'b0, BPE_ROLE_MASTER, 2'h3, 2'(k)));
            seen(12, 2'h3);
            seen(240, 2'h3);
            check(32'(hit), 32'(k == 0));
            below_off = below_on;
            below_on = 3'h0;
            seen(240, 2'h3);
            check(32'(hit), 32'h1);
            below_off = 3'h0;
        end
        // A single chip here, so its own threshold is trivially the shared one.
        pins(1'b1, 1'b0, 1'b1, 1'b1);
        seen(12, 2'h3);
        seen(240, 2'h3);
        check(32'(hit), 32'h0);
        pins(1'b0, 1'b0, 1'b1, 1'b1);
        apb(1'b1, BPE_CTRL_OFS, ctrl(2'h0, 1'b0, 1'b0, BPE_ROLE_MASTER, 2'h3, BPE_SKIP_OFF));
        seen(12, 2'h3);
        seen(240, 2'h3);
        check({28'h0, hit, amp_en_o, drive_o, 1'b0}, 32'h6);
        apb(1'b1, BPE_CTRL_OFS, ctrl(2'h3, 1'b1, 1'b0, BPE_ROLE_MASTER, 2'h3, BPE_SKIP_OFF));
        pins(1'b0, 1'b1, 1'b1, 1'b1);
        repeat (2) @(posedge clk_i);
        pins(1'b0, 1'b0, 1'b0, 1'b1);
        seen(240, 2'h1);
        check({30'h0, hit, fsm_o}, 32'h0);
        pins(1'b0, 1'b1, 1'b0, 1'b1);
        seen(250, 2'h1);
        check(32'(hit), 32'h1);
        pins(1'b0, 1'b0, 1'b1, 1'b0);
        ffs = 3'($urandom);
        apb(1'b1, BPE_CTRL_OFS, ctrl(2'h0, 1'b0, 1'b0, BPE_ROLE_MASTER, 2'h3, BPE_SKIP_OFF));
        apb(1'b1, BPE_CTRL_OFS, ctrl(2'h3, 1'b0, 1'b0, BPE_ROLE_MASTER, 2'h3, BPE_SKIP_OFF));
        seen(12, 2'h0);
        pins(1'b0, 1'b0, 1'b0, 1'b0);
        for (d = 0; d < 20 && fsm_o !== 1'b1; d++) begin
            seen(1, 2'h0);
        end
        if (d == 20) give_up();
        seen(400, 2'h3);
        check(32'(hit), 32'h1);
        rise0(d);
        rise0(d);
        check(d, fs_exp(ffs));
        apb(1'b0, BPE_STAT_OFS, 32'h0);
        check(32'(rd[1]), 32'h1);
        apb(1'b1, BPE_FSCLR_OFS, 32'h1);
        check(32'(fsm_o), 32'h0);
        close_out();
    end
endmodule
